// >>> include/rsvc_pkg.sv
// package for the reference select and vco calibration controller of the first loop
// assumes a byte-wide register port fed by the serial port front end
package rsvc_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [15:0] ADDR_UPDATE   = 16'h0005;
   localparam logic [15:0] ADDR_STATUS   = 16'h0080;
   localparam logic [15:0] ADDR_CAL_SYNC = 16'h0100;
   localparam logic [15:0] ADDR_DIV_CFG  = 16'h0101;
   localparam logic [15:0] ADDR_REF_SW   = 16'h0102;
   // ------------------------------------------------------------
   // field positions and reset values
   // ------------------------------------------------------------
   localparam int UPD_BIT       = 0;
   localparam int STAT_REF_BIT  = 0;
   localparam int STAT_DONE_BIT = 1;
   localparam int STAT_BUSY_BIT = 4;
   localparam int MAN_CAL_BIT   = 1;
   localparam int MAN_SYNC_BIT  = 2;
   localparam int LOOP_LSB      = 0;
   localparam int LOOP4_EXT_BIT = 2;
   localparam int FIXDLY_LSB    = 5;
   localparam int AUTOSW_BIT    = 0;
   localparam int SWSEL_BIT     = 4;
   localparam int SWEN_BIT      = 5;
   localparam logic [7:0] REG_RESET = 8'h00;
   // ------------------------------------------------------------
   // loop configurations and timing
   // ------------------------------------------------------------
   localparam logic [1:0] LOOP_1 = 2'h0;
   localparam logic [1:0] LOOP_2 = 2'h1;
   localparam logic [1:0] LOOP_3 = 2'h2;
   localparam logic [1:0] LOOP_4 = 2'h3;
   localparam int CAL_PFD_CYCLES = 172000;
   localparam int CAL_CNT_W      = 18;

   typedef enum logic [1:0] {CAL_IDLE, CAL_WAIT_REF, CAL_RUN} rsvc_cal_st_t;

   typedef struct packed {
      logic        wr_en;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } rsvc_reg_req_t;

   typedef struct packed {
      logic primary;
      logic secondary;
   } rsvc_loss_t;

   typedef struct packed {
      logic [7:0]           stg_cal_sync;
      logic [7:0]           stg_div_cfg;
      logic [7:0]           stg_ref_sw;
      logic [7:0]           act_cal_sync;
      logic [7:0]           act_div_cfg;
      logic [7:0]           act_ref_sw;
      logic                 upd_pulse;
      logic [7:0]           rd_data;
      logic                 auto_ref;
      logic                 active_ref;
      logic                 boot_taken;
      logic                 man_cal_prev;
      rsvc_cal_st_t         cal_st;
      logic [CAL_CNT_W-1:0] cal_cnt;
      logic                 cal_busy;
      logic                 cal_done;
      logic                 div_hold;
      logic [1:0]           loop_eff;
      logic [3:0]           cp_current;
   } rsvc_state_t;
endpackage

// >>> rtl/rsvc_ctrl.sv
// reference selection and internal vco calibration sequencing for the first loop
// assumes register writes arrive as one-cycle requests and all inputs are synchronous to clk
//
// Overview of operation
// - with pin selection, pin low picks primary reference, high picks secondary.
// - automatic switching enabled means the reference choose pin is ignored.
// - software select bit is disregarded while its enable bit is clear.
// - enabled software select: 0 picks primary, 1 picks secondary reference.
// - enabled software select wins over automatic switching and the pin.
// - automatic selection from loss status only while autoswitch bit is 1.
// - switch only if active reference lost and alternate not; else keep.
// - after a switch roles swap; no revert, switch back only on new loss.
// - calibration applies only for loop 1, loop 2, or internal loop 4.
// - power-up calibration if profile asks; otherwise via manual calibrate bit.
// - calibration waits for a valid reference, then runs the lock sequence.
// - internal loop 4 runs calibration as loop 1, restored when done.
// - charge pump setting derived from feedback divider during calibration.
// - channel dividers held during calibration; busy flag falls at completion.
// - calibration lasts about 172,000 phase detector cycles.
`timescale 1ns/100ps

module rsvc_ctrl
   import rsvc_pkg::*;
#(
   parameter int CAL_CYCLES = CAL_PFD_CYCLES
) (
   input  wire logic                   clk,
   input  wire logic                   reset_n,
   input  wire rsvc_pkg::rsvc_reg_req_t reg_req,
   output      logic [7:0]             reg_rd_data,
   input  wire logic                   reference_choose_pin,
   input  wire rsvc_pkg::rsvc_loss_t   reference_loss,
   input  wire logic                   reference_valid,
   input  wire logic                   profile_cal_cmd,
   input  wire logic                   pfd_tick,
   input  wire logic [7:0]             feedback_divider,
   output      logic                   active_reference,
   output      logic                   cal_in_progress,
   output      logic                   divider_hold,
   output      logic [1:0]             loop_cfg_effective,
   output      logic [1:0]             channel_divider_sel,
   output      logic [3:0]             cp_current
);
   import rsvc_pkg::*;

   // ------------------------------------------------------------
   // decode helpers
   // ------------------------------------------------------------
   function automatic logic cal_allowed(input logic [7:0] cfg);
      logic [1:0] lp;
      lp = cfg[LOOP_LSB +: 2];
      return (lp == LOOP_1) || (lp == LOOP_2) ||
             (lp == LOOP_4 && !cfg[LOOP4_EXT_BIT]);
   endfunction

   function automatic logic loop4_internal(input logic [7:0] cfg);
      return (cfg[LOOP_LSB +: 2] == LOOP_4) && !cfg[LOOP4_EXT_BIT];
   endfunction

   // coarse current code: larger feedback ratio needs more pump current
   function automatic logic [3:0] cp_from_div(input logic [7:0] div);
      return (div[7:4] == 4'h0) ? 4'h1 : div[7:4];
   endfunction

   rsvc_state_t st_q;
   rsvc_state_t st_d;

   logic       cal_req;
   logic       run_done;
   logic       cur_lost;
   logic       alt_lost;
   logic       sw_en;
   logic       autosw;
   logic       auto_next;

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_d = st_q;

      // register port: config writes land in staging copies only; the update write sets upd_pulse
      st_d.upd_pulse = 1'b0;
      if (reg_req.wr_en) begin
         unique case (reg_req.addr)
            ADDR_UPDATE:   st_d.upd_pulse = reg_req.wdata[UPD_BIT];
            ADDR_CAL_SYNC: st_d.stg_cal_sync = reg_req.wdata;
            ADDR_DIV_CFG:  st_d.stg_div_cfg = reg_req.wdata;
            ADDR_REF_SW:   st_d.stg_ref_sw = reg_req.wdata;
            default:       st_d.upd_pulse = 1'b0;
         endcase
      end
      if (st_q.upd_pulse) begin
         // staged values become live one cycle after the update write
         st_d.act_cal_sync = st_q.stg_cal_sync;
         st_d.act_div_cfg  = st_q.stg_div_cfg;
         st_d.act_ref_sw   = st_q.stg_ref_sw;
      end

      unique case (reg_req.addr)
         ADDR_UPDATE:   st_d.rd_data = {7'h00, st_q.upd_pulse};
         ADDR_STATUS:   st_d.rd_data = {3'h0, st_q.cal_busy, 2'h0,
                                        st_q.cal_done, st_q.active_ref};
         ADDR_CAL_SYNC: st_d.rd_data = st_q.stg_cal_sync;
         ADDR_DIV_CFG:  st_d.rd_data = st_q.stg_div_cfg;
         ADDR_REF_SW:   st_d.rd_data = st_q.stg_ref_sw;
         default:       st_d.rd_data = 8'h00;
      endcase

      // reference selection
      sw_en    = st_q.act_ref_sw[SWEN_BIT];
      autosw   = st_q.act_ref_sw[AUTOSW_BIT];
      cur_lost = st_q.auto_ref ? reference_loss.secondary : reference_loss.primary;
      alt_lost = st_q.auto_ref ? reference_loss.primary : reference_loss.secondary;
      if (autosw) begin
         // nonrevertive: only loss of the current one moves it
         auto_next = (cur_lost && !alt_lost) ? !st_q.auto_ref : st_q.auto_ref;
      end else if (sw_en) begin
         // track the software select bit already live, not the one going live this edge; the registered choice would lag the pin
         // by one cycle and make the reference jump when autoswitch is enabled
         auto_next = st_q.act_ref_sw[SWSEL_BIT];
      end else begin
         auto_next = reference_choose_pin;
      end
      st_d.auto_ref = auto_next;
      if (sw_en) begin
         st_d.active_ref = st_q.act_ref_sw[SWSEL_BIT];
      end else if (autosw) begin
         st_d.active_ref = auto_next;
      end else begin
         st_d.active_ref = reference_choose_pin;
      end

      // calibration requests: strap on first clock, or rising manual bit
      st_d.boot_taken   = 1'b1;
      st_d.man_cal_prev = st_q.act_cal_sync[MAN_CAL_BIT];
      cal_req = (!st_q.boot_taken && profile_cal_cmd) ||
                (st_q.act_cal_sync[MAN_CAL_BIT] && !st_q.man_cal_prev);
      run_done = pfd_tick && (st_q.cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1));

      unique case (st_q.cal_st)
         CAL_IDLE: begin
            if (cal_req && cal_allowed(st_q.act_div_cfg)) begin
               st_d.cal_st   = CAL_WAIT_REF;
               st_d.cal_busy = 1'b1;
               st_d.cal_done = 1'b0;
            end
         end
         CAL_WAIT_REF: begin
            // stays here indefinitely without a validated reference
            if (reference_valid) begin
               st_d.cal_st     = CAL_RUN;
               st_d.cal_cnt    = '0;
               st_d.cp_current = cp_from_div(feedback_divider);
            end
         end
         CAL_RUN: begin
            if (pfd_tick) begin
               st_d.cal_cnt = st_q.cal_cnt + 1'b1;
            end
            if (run_done) begin
               st_d.cal_st   = CAL_IDLE;
               st_d.cal_busy = 1'b0;
               st_d.cal_done = 1'b1;
            end
         end
      endcase

      // loop 4 internal borrows loop 1 while calibrating
      // decoded from the config going live, so an update never leaves it one cycle stale
      if (st_d.cal_st != CAL_IDLE && loop4_internal(st_d.act_div_cfg)) begin
         st_d.loop_eff = LOOP_1;
      end else begin
         st_d.loop_eff = st_d.act_div_cfg[LOOP_LSB +: 2];
      end
      st_d.div_hold = (st_d.cal_st != CAL_IDLE) ||
                      st_q.act_cal_sync[MAN_SYNC_BIT];
   end

   // ------------------------------------------------------------
   // state register
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_q <= '{stg_cal_sync: REG_RESET, stg_div_cfg: REG_RESET,
                   stg_ref_sw: REG_RESET, act_cal_sync: REG_RESET,
                   act_div_cfg: REG_RESET, act_ref_sw: REG_RESET,
                   cal_st: CAL_IDLE, default: '0};
      end else begin
         st_q <= st_d;
      end
   end

   assign reg_rd_data         = st_q.rd_data;
   assign active_reference    = st_q.active_ref;
   assign cal_in_progress     = st_q.cal_busy;
   assign divider_hold        = st_q.div_hold;
   assign loop_cfg_effective  = st_q.loop_eff;
   assign channel_divider_sel = st_q.act_div_cfg[FIXDLY_LSB +: 2];
   assign cp_current          = st_q.cp_current;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   wire sw_on   = st_q.act_ref_sw[SWEN_BIT];
   wire auto_on = st_q.act_ref_sw[AUTOSW_BIT];

   pin_select_a: assert property (
      (!sw_on && !auto_on && !st_q.upd_pulse) |=> active_reference == $past(reference_choose_pin))
      else $error("pin selection not followed");

   pin_ignored_a: assert property (
      (auto_on && !sw_on && !st_q.upd_pulse && !reference_loss.primary &&
       !reference_loss.secondary) |=> $stable(active_reference))
      else $error("pin moved reference under autoswitch");

   sw_select_a: assert property (
      (sw_on && !st_q.upd_pulse) |=> active_reference == $past(st_q.act_ref_sw[SWSEL_BIT]))
      else $error("software select not followed");

   sw_priority_a: assert property (
      (sw_on && !st_q.upd_pulse) ##1 (sw_on && !st_q.upd_pulse)
         |=> $stable(active_reference))
      else $error("software select overridden");

   auto_switch_a: assert property (
      (auto_on && !sw_on && !st_q.upd_pulse && st_q.active_ref == st_q.auto_ref &&
       (st_q.auto_ref ? reference_loss.secondary : reference_loss.primary) &&
       !(st_q.auto_ref ? reference_loss.primary : reference_loss.secondary))
         |=> active_reference != $past(active_reference))
      else $error("no switch on active loss");

   no_revert_a: assert property (
      (auto_on && !sw_on && !st_q.upd_pulse &&
       !(st_q.auto_ref ? reference_loss.secondary : reference_loss.primary))
         |=> st_q.auto_ref == $past(st_q.auto_ref))
      else $error("reverted without loss");

   cal_gate_a: assert property (
      (st_q.cal_st == CAL_IDLE && !cal_allowed(st_q.act_div_cfg)) |=> !cal_in_progress)
      else $error("calibration on external loop");

   wait_ref_a: assert property (
      (st_q.cal_st == CAL_WAIT_REF && !reference_valid) |=> st_q.cal_st == CAL_WAIT_REF)
      else $error("left wait without reference");

   loop_swap_a: assert property (
      (cal_in_progress && loop4_internal(st_q.act_div_cfg) && !st_q.upd_pulse)
         |-> loop_cfg_effective == LOOP_1)
      else $error("loop 4 not replaced during calibration");

   hold_busy_a: assert property (
      cal_in_progress |-> divider_hold)
      else $error("dividers released during calibration");

   cal_len_a: assert property (
      (st_q.cal_st == CAL_RUN && pfd_tick && st_q.cal_cnt == CAL_CNT_W'(CAL_CYCLES - 1))
         |=> $fell(cal_in_progress) && st_q.cal_done)
      else $error("calibration length wrong");

   staged_a: assert property (
      !st_q.upd_pulse |=> $stable(st_q.act_ref_sw) && $stable(st_q.act_div_cfg))
      else $error("live control changed without update");

   upd_clear_a: assert property (
      st_q.upd_pulse && !(reg_req.wr_en && reg_req.addr == ADDR_UPDATE) |=> !st_q.upd_pulse)
      else $error("update bit did not clear");

   upd_set_a: assert property (
      (reg_req.wr_en && reg_req.addr == ADDR_UPDATE && reg_req.wdata[UPD_BIT])
         |=> st_q.upd_pulse)
      else $error("update write not taken");

   busy_status_a: assert property (
      (reg_req.addr == ADDR_STATUS) |=> reg_rd_data[STAT_BUSY_BIT] == $past(cal_in_progress))
      else $error("status busy bit wrong");

   boot_cal_a: assert property (
      (!st_q.boot_taken && profile_cal_cmd && cal_allowed(st_q.act_div_cfg))
         |=> cal_in_progress)
      else $error("power-up calibration not started");

   man_cal_a: assert property (
      (st_q.cal_st == CAL_IDLE && st_q.act_cal_sync[MAN_CAL_BIT] && !st_q.man_cal_prev &&
       cal_allowed(st_q.act_div_cfg)) |=> cal_in_progress)
      else $error("manual calibrate bit ignored");

   cp_load_a: assert property (
      (st_q.cal_st == CAL_WAIT_REF && reference_valid && feedback_divider[7:4] != 4'h0)
         |=> cp_current == $past(feedback_divider[7:4]))
      else $error("pump current not taken from divider");

   cal_done_c: cover property ($fell(cal_in_progress));
   auto_sw_c: cover property (auto_on && $changed(active_reference));
   loop4_cal_c: cover property (cal_in_progress && loop4_internal(st_q.act_div_cfg));
   boot_cal_c: cover property (!st_q.boot_taken && profile_cal_cmd);
   man_sync_c: cover property (divider_hold && !cal_in_progress);
endmodule

// >>> tb/rsvc_ctrl_tb.sv
// testbench: reference choice and calibration sequencing of the controller
// assumes a calibration length shortened to CAL_N phase detector ticks
`timescale 1ns/100ps
module rsvc_ctrl_tb;
   import rsvc_pkg::*;
   localparam int CAL_N = 8;
   logic          clk = 1'b0;
   logic          reset_n = 1'b0;
   rsvc_reg_req_t reg_req;
   logic [7:0]    rdd;
   logic [7:0]    fb = 8'h50;
   logic          pin = 1'b0;
   logic          valid = 1'b0;
   logic          prof = 1'b0;
   logic          tick = 1'b0;
   rsvc_loss_t    loss = '0;
   logic          act;
   logic          busy;
   logic          hold;
   logic [1:0]    loop_eff;
   logic [1:0]    ch_sel;
   logic [3:0]    cp;
   logic [7:0]    v;
   int            mismatches = 0;
   int            n_checks = 0;
   always #2.5 clk = ~clk;
   rsvc_ctrl #(.CAL_CYCLES(CAL_N)) DUT (.clk(clk), .reset_n(reset_n), .reg_req(reg_req),
      .reg_rd_data(rdd), .reference_choose_pin(pin), .reference_loss(loss),
      .reference_valid(valid), .profile_cal_cmd(prof), .pfd_tick(tick),
      .feedback_divider(fb), .active_reference(act), .cal_in_progress(busy),
      .divider_hold(hold), .loop_cfg_effective(loop_eff),
      .channel_divider_sel(ch_sel), .cp_current(cp));
   rsvc_host host (.clk(clk), .reg_rd_data(rdd), .reg_req(reg_req));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic ticks(input int n);
      repeat (n) begin
         tick = 1'b1;
         cyc(1);
         tick = 1'b0;
         cyc(1);
      end
   endtask
   task automatic set_sw(input logic [7:0] d);
      host.wr(ADDR_REF_SW, d);
      host.upd();
      cyc(3);
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      logic [15:0] a [6] = '{ADDR_UPDATE, ADDR_STATUS, ADDR_CAL_SYNC, ADDR_DIV_CFG,
                             ADDR_REF_SW, 16'h0042};
      host.wr(ADDR_STATUS, 8'hFF);
      foreach (a[i]) begin
         host.rd(a[i], v);
         chk(v, REG_RESET);
      end
      chk(8'({act, busy, hold}), 8'h00);
   endtask
   task automatic t_auto();
      set_sw(8'h01);
      pin = 1'b1;
      cyc(2);
      chk(8'(act), 8'h00);
      loss = 2'b10;
      cyc(2);
      chk(8'(act), 8'h01);
      loss = 2'b00;
      cyc(3);
      chk(8'(act), 8'h01);
      loss = 2'b11;
      cyc(2);
      chk(8'(act), 8'h01);
      loss = 2'b01;
      cyc(2);
      chk(8'(act), 8'h00);
      loss = 2'b00;
   endtask
   task automatic t_sw();
      pin = 1'b0;
      host.wr(ADDR_REF_SW, 8'h31);
      cyc(3);
      chk(8'(act), 8'h00);
      host.rd(ADDR_REF_SW, v);
      chk(v, 8'h31);
      host.upd();
      cyc(3);
      chk(8'(act), 8'h01);
      loss = 2'b01;
      cyc(2);
      chk(8'(act), 8'h01);
      host.rd(ADDR_UPDATE, v);
      chk(v, 8'h00);
      loss = 2'b00;
      pin = 1'b1;
      set_sw(8'h21);
      chk(8'(act), 8'h00);
   endtask
   task automatic t_pin();
      pin = 1'b0;
      set_sw(8'h10);
      chk(8'(act), 8'h00);
      loss = 2'b10;
      cyc(2);
      chk(8'(act), 8'h00);
      pin = 1'b1;
      cyc(2);
      chk(8'(act), 8'h01);
      loss = 2'b00;
   endtask
   task automatic t_cal();
      // feedback divider equals vco divider times channel divider for loop 4
      fb = 8'h50;
      host.wr(ADDR_DIV_CFG, 8'h43);
      host.recal();
      cyc(2);
      chk(8'({busy, hold}), 8'h03);
      chk(8'(loop_eff), 8'(LOOP_1));
      chk(8'(ch_sel), 8'h02);
      ticks(CAL_N + 2);
      chk(8'(busy), 8'h01);
      valid = 1'b1;
      cyc(3);
      ticks(CAL_N - 1);
      chk(8'(busy), 8'h01);
      chk(8'(cp), 8'h05);
      ticks(1);
      chk(8'({busy, hold}), 8'h00);
      chk(8'(loop_eff), 8'(LOOP_4));
      host.rd(ADDR_STATUS, v);
      chk(v, 8'h03);
   endtask
   task automatic t_loops();
      logic [7:0] cfg [3] = '{8'h02, 8'h07, 8'h01};
      fb = 8'h0F;
      foreach (cfg[i]) begin
         host.wr(ADDR_DIV_CFG, cfg[i]);
         host.recal();
         cyc(2);
         chk(8'(busy), (i == 2) ? 8'h01 : 8'h00);
      end
      cyc(2);
      chk(8'(cp), 8'h01);
      ticks(CAL_N);
      chk(8'(busy), 8'h00);
      host.wr(ADDR_CAL_SYNC, 8'h04);
      cyc(2);
      chk(8'(hold), 8'h00);
      host.upd();
      cyc(2);
      chk(8'(hold), 8'h01);
   endtask
   task automatic t_boot();
      reset_n = 1'b0;
      prof = 1'b1;
      cyc(2);
      reset_n = 1'b1;
      cyc(2);
      chk(8'(busy), 8'h01);
   endtask
   initial begin
      #20000;
      mismatches++;
      test_done();
   end
   initial begin
      cyc(3);
      reset_n = 1'b1;
      t_reset();
      t_auto();
      t_sw();
      t_pin();
      t_cal();
      t_loops();
      t_boot();
      test_done();
   end
endmodule

// >>> tb/rsvc_host.sv
// host model: byte-wide register writes and reads into the controller
// assumes the testbench calls its tasks and that clk is shared with the block
`timescale 1ns/100ps
module rsvc_host
   import rsvc_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic [7:0]              reg_rd_data,
   output      rsvc_pkg::rsvc_reg_req_t reg_req
);
   initial begin
      reg_req = '0;
   end
   // ------------------------------------------------------------
   // bus cycles
   // ------------------------------------------------------------
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      #1 reg_req <= '{1'b1, a, d};
      @(posedge clk);
      #1 reg_req.wr_en <= 1'b0;
   endtask
   task automatic upd();
      wr(ADDR_UPDATE, 8'h01);
   endtask
   // read data is registered, so it is taken one edge after the address
   task automatic rd(input logic [15:0] a, output logic [7:0] d);
      @(posedge clk);
      #1 reg_req.addr <= a;
      @(posedge clk);
      #1 d = reg_rd_data;
   endtask
   // only a rising calibrate bit starts a run, hence clear then set
   task automatic recal();
      wr(ADDR_CAL_SYNC, 8'h00);
      upd();
      wr(ADDR_CAL_SYNC, 8'h02);
      upd();
   endtask
endmodule
